// [bench/bpm_ctrl_checker.sv]
// bpm_ctrl_checker: port-level assertions for the protector mode block
// assumes it is bound to bpm_ctrl, one core_clk domain, sync active-low reset
`timescale 1ns/100ps
`default_nettype none
module bpm_ctrl_checker #(
   parameter int WAKE_HOLD_CYCLES = 20
) (
   input wire logic core_clk,
   input wire logic resetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic charge_switch_on,
   input wire logic charge_switch_off,
   input wire logic charge_switch_to_pack,
   input wire logic discharge_switch_on,
   input wire logic discharge_switch_off,
   input wire logic probe_load_en,
   input wire logic regulator_en,
   input wire logic meas_start,
   input wire logic comm_hold_low
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!resetn);
   // length of the current hold, too long to unroll as a repetition
   logic [31:0] hold_q;
   logic [31:0] hold_d;
   assign hold_d = comm_hold_low ? hold_q + 32'h1 : 32'h0;
   always_ff @(posedge core_clk) begin
      if (!resetn) hold_q <= 32'h0;
      else hold_q <= hold_d;
   end
   a_apb_one_wait: assert property (psel && penable && !pready |=> pready)
      else $error("apb answer missing after one wait state");
   a_ready_one_cycle: assert property (pready |=> !pready)
      else $error("pready longer than one cycle");
   a_err_with_ready: assert property (pslverr |-> pready)
      else $error("pslverr without pready");
   a_rdata_quiet: assert property (!pready |-> prdata == 32'h0)
      else $error("prdata nonzero outside answer");
   a_chg_drive_excl: assert property (charge_switch_on |-> !charge_switch_off && !charge_switch_to_pack)
      else $error("charge gate driven two ways");
   a_dsg_drive_excl: assert property (!(discharge_switch_on && discharge_switch_off))
      else $error("discharge gate driven two ways");
   a_probe_dsg_open: assert property (probe_load_en |-> discharge_switch_off && !discharge_switch_on)
      else $error("probe load with discharge switch closed");
   a_reg_off_open: assert property (!regulator_en && !charge_switch_to_pack |-> charge_switch_off && discharge_switch_off)
      else $error("switch closed with regulator off");
   a_meas_pulse: assert property (meas_start |=> !meas_start)
      else $error("measurement start longer than one cycle");
   a_wake_hold_max: assert property (hold_q <= WAKE_HOLD_CYCLES)
      else $error("comm lines held low too long");
endmodule : bpm_ctrl_checker
bind bpm_ctrl bpm_ctrl_checker #(.WAKE_HOLD_CYCLES(WAKE_HOLD_CYCLES)) u_bpm_ctrl_checker (.*);
`default_nettype wire

// [bench/bpm_pack_model.sv]
// bpm_pack_model: pack side load, seen through closed switch or probe resistor
// assumes load_attached is set by the bench
`timescale 1ns/100ps
`default_nettype none
module bpm_pack_model (
   input wire logic probe_load_en,
   input wire logic discharge_switch_on,
   input wire logic load_attached,
   output logic load_present
);
   // an open switch hides the load unless the probe resistor is
   assign load_present = load_attached & (probe_load_en | discharge_switch_on);
endmodule : bpm_pack_model
`default_nettype wire

// [bench/testbench.sv]
// testbench: apb driven scenarios for the protector mode block
// assumes short second and wake-hold counts set by parameter
`timescale 1ns/100ps
`default_nettype none
module testbench;
   logic core_clk, resetn, psel, penable, pwrite, pready, pslverr, wake_cmp, host_activity;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [15:0] mean_current, temperature;
   logic charger_present, load_present, lv_charge_allowed, cell_above_por, cell_below_uv;
   logic cell_above_uv_release, cell_below_ov_release, charger_below_cell, load_attached;
   logic discharge_overcurrent, discharge_short_circuit, charge_overcurrent, overvoltage_fault;
   logic charge_switch_on, charge_switch_off, charge_switch_to_pack, discharge_switch_on;
   logic discharge_switch_off, probe_load_en, regulator_en, hf_osc_en, meas_start, adc_cal;
   logic comm_hold_low, er;
   int n_errors, checked, cyc;
   localparam int WHOLD = 20;
   localparam logic [7:0] CT = bpm_pkg::BPM_CTRL_OFS;
   localparam logic [7:0] ST = bpm_pkg::BPM_STATUS_OFS;
   localparam logic [7:0] TS = bpm_pkg::BPM_TEST_OFS;
   localparam logic [7:0] FW = bpm_pkg::BPM_DEEP_SLEEP_WAIT_TIME_OFS;
   bpm_ctrl #(.SEC_CYCLES(100), .WAKE_HOLD_CYCLES(WHOLD), .DEEP_MEAS_DIV(4)) u_bpm_ctrl (.*);
   bpm_pack_model u_bpm_pack_model (.*);
   initial begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end
   task wrap_up;
      $display("errors %0d checks %0d", n_errors, checked);
      if (n_errors == 0 && checked > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : wrap_up
   always @(posedge core_clk) begin
      cyc <= cyc + 1;
      if (cyc == 60000) begin
         n_errors++;
         $display("FAIL %0t run too long", $time);
         wrap_up();
      end
   end
   task automatic chk(input logic ok, input string m);
      checked++;
      if (ok !== 1'b1) begin
         n_errors++;
         $display("FAIL %0t %s", $time, m);
      end
   endtask : chk
   // read data taken at the edge where pready is sampled high
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
      @(posedge core_clk);
      psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= wd;
      @(posedge core_clk);
      penable <= 1'b1;
      do @(posedge core_clk); while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0; penable <= 1'b0;
   endtask : apb
   // polls a status field until it matches
   task automatic wait_st(input int sh, input logic [2:0] exp);
      for (int i = 0; i < 400; i++) begin
         apb(1'b0, ST, 32'h0);
         if (rd[sh+:3] === exp) break;
      end
      chk(rd[sh+:3] === exp, "status field mismatch");
   endtask : wait_st
   logic [7:0] ofs [6] = '{8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18};
   logic [15:0] rv [6] = '{bpm_pkg::BPM_SLEEP_CUR_RST, bpm_pkg::BPM_DEEP_SLEEP_WAIT_TIME_RST,
      bpm_pkg::BPM_OT_THR_RST, bpm_pkg::BPM_OT_DLY_RST, bpm_pkg::BPM_OT_REC_RST,
      bpm_pkg::BPM_FLT_DLY_RST};
   initial begin
      int n;
      {resetn, psel, penable, pwrite, paddr, pwdata, wake_cmp, host_activity} = '0;
      {charger_present, lv_charge_allowed, cell_above_por, cell_below_uv} = 4'h8;
      {cell_above_uv_release, cell_below_ov_release, charger_below_cell} = '0;
      {discharge_overcurrent, discharge_short_circuit, charge_overcurrent} = '0;
      {overvoltage_fault, n_errors, checked, cyc} = '0;
      mean_current = 16'h0100;
      temperature = 16'h0100;
      load_attached = 1'b1;
      repeat (3) @(posedge core_clk);
      resetn <= 1'b1;
      apb(1'b0, ST, 32'h0);
      chk(rd[5:3] === bpm_pkg::BPM_PS_UVF && rd[8:6] === bpm_pkg::BPM_PM_NORMAL, "reset state");
      chk(charge_switch_off === 1'b1 && discharge_switch_off === 1'b1, "reset switches");
      for (int i = 0; i < 6; i++) begin
         apb(1'b0, ofs[i], 32'h0);
         chk(rd === {16'h0000, rv[i]} && er === 1'b0, "reset value");
      end
      apb(1'b0, 8'h24, 32'h0);
      chk(er === 1'b1 && rd === 32'h0, "unmapped read");
      cell_above_uv_release <= 1'b1;
      wait_st(3, bpm_pkg::BPM_PS_NORMAL);
      chk(charge_switch_on === 1'b1 && discharge_switch_on === 1'b1, "normal switches");
      n = 0;
      repeat (250) @(posedge core_clk) if (meas_start === 1'b1) n++;
      chk(n >= 2 && n <= 3, "measurement rate");
      apb(1'b1, CT, 32'h8);
      apb(1'b0, CT, 32'h0);
      chk(rd === 32'h8 && charge_switch_off === 1'b1 && discharge_switch_on === 1'b1, "fw open");
      wait_st(3, bpm_pkg::BPM_PS_NORMAL);
      apb(1'b1, CT, 32'h0);
      repeat (4) @(posedge core_clk);
      chk(charge_switch_on === 1'b1, "fw release");
      apb(1'b1, TS, 32'h2);
      repeat (4) @(posedge core_clk);
      chk(discharge_switch_off === 1'b1, "switch test");
      apb(1'b1, TS, 32'h0);
      discharge_short_circuit <= 1'b1;
      repeat (5) @(posedge core_clk);
      discharge_short_circuit <= 1'b0;
      repeat (30) @(posedge core_clk);
      wait_st(3, bpm_pkg::BPM_PS_NORMAL);
      discharge_overcurrent <= 1'b1;
      wait_st(3, bpm_pkg::BPM_PS_DSGF);
      chk(probe_load_en === 1'b1 && discharge_switch_off === 1'b1, "probe load");
      discharge_overcurrent <= 1'b0;
      load_attached <= 1'b0;
      wait_st(3, bpm_pkg::BPM_PS_NORMAL);
      load_attached <= 1'b1;
      charge_overcurrent <= 1'b1;
      wait_st(3, bpm_pkg::BPM_PS_OCCF);
      chk(charge_switch_off === 1'b1 && discharge_switch_on === 1'b1, "occ switches");
      charge_overcurrent <= 1'b0;
      charger_below_cell <= 1'b1;
      wait_st(3, bpm_pkg::BPM_PS_NORMAL);
      charger_below_cell <= 1'b0;
      overvoltage_fault <= 1'b1;
      wait_st(3, bpm_pkg::BPM_PS_OVF);
      overvoltage_fault <= 1'b0;
      charger_below_cell <= 1'b1;
      repeat (30) @(posedge core_clk);
      apb(1'b0, ST, 32'h0);
      chk(rd[5:3] === bpm_pkg::BPM_PS_OVF, "ovp held without release");
      cell_below_ov_release <= 1'b1;
      wait_st(3, bpm_pkg::BPM_PS_NORMAL);
      charger_below_cell <= 1'b0;
      temperature <= 16'h0300;
      repeat (450) @(posedge core_clk);
      chk(charge_switch_off === 1'b1 && discharge_switch_off === 1'b1, "ot open");
      temperature <= 16'h0100;
      repeat (250) @(posedge core_clk);
      chk(charge_switch_on === 1'b1 && discharge_switch_on === 1'b1, "ot release");
      apb(1'b1, CT, 32'h1);
      mean_current <= 16'h0005;
      wait_st(6, bpm_pkg::BPM_PM_CAL);
      chk(adc_cal === 1'b1, "calibration");
      wait_st(6, bpm_pkg::BPM_PM_SLEEP);
      mean_current <= 16'h0100;
      wait_st(6, bpm_pkg::BPM_PM_NORMAL);
      apb(1'b1, FW, 32'h2);
      mean_current <= 16'h0005;
      wait_st(6, bpm_pkg::BPM_PM_DEEP);
      chk(hf_osc_en === 1'b0, "oscillator in deep sleep");
      host_activity <= 1'b1;
      for (int i = 0; i < 40 && comm_hold_low !== 1'b1; i++) @(posedge core_clk);
      host_activity <= 1'b0;
      n = 0;
      while (comm_hold_low === 1'b1 && n < 100) begin
         @(posedge core_clk);
         n++;
      end
      chk(n > 0 && n <= WHOLD, "wake hold length");
      apb(1'b1, FW, 32'h0);
      apb(1'b1, CT, 32'h3);
      wait_st(6, bpm_pkg::BPM_PM_DEEP);
      chk(rd[9] === 1'b1, "deep flag set");
      apb(1'b1, CT, 32'h0);
      wake_cmp <= 1'b1;
      wait_st(6, bpm_pkg::BPM_PM_NORMAL);
      chk(rd[9] === 1'b0, "deep flag clear");
      {wake_cmp, mean_current} <= {1'b0, 16'h0100};
      charger_present <= 1'b1;
      apb(1'b1, CT, 32'h4);
      wait_st(3, bpm_pkg::BPM_PS_SDWAIT);
      chk(charge_switch_off === 1'b1 && discharge_switch_off === 1'b1, "sd wait open");
      charger_present <= 1'b0;
      wait_st(3, bpm_pkg::BPM_PS_ASHUT);
      chk(regulator_en === 1'b0, "regulator off");
      {cell_above_uv_release, cell_below_uv, lv_charge_allowed, charger_present} <= 4'h7;
      wait_st(3, bpm_pkg::BPM_PS_LVCHG);
      chk(charge_switch_to_pack === 1'b1, "gate to pack");
      cell_above_por <= 1'b1;
      wait_st(3, bpm_pkg::BPM_PS_UVF);
      charger_present <= 1'b0;
      wait_st(3, bpm_pkg::BPM_PS_ASHUT);
      wrap_up();
   end
endmodule : testbench
`default_nettype wire

// [hdl/bpm_ctrl.sv]
// bpm_ctrl: power mode sequencer and protector state machine with apb registers
// assumes analog comparators and measurements arrive asynchronously on pins
//
// The placing of the registers and the APB register port were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
// Summary of operation
// - normal mode default, measurements and updates
// - sleep needs enable and low current
// - offset calibration before entering sleep
// - wake on current rise or comparator
// - deep request with zero wait enters
// - nonzero wait counts down in sleep
// - deep sleep stops oscillator, slower measuring
// - host activity ends deep sleep
// - hold comm lines low up to 4ms
// - gate boosted on, grounded off, test off
// - charger in shutdown allows low-voltage charging
// - gate tied to pack until por
// - undervoltage, charger leaves, go shutdown
// - undervoltage entered, released above release level
// - normal closes both, firmware open stateless
// - shutdown bit enters shutdown wait
// - open, fault returns, charger gone shutdown
// - discharge fault, probe load, clear removal
// - charge overcurrent clears on charger drop
// - overvoltage clears on drop and release
// - firmware may open, never close
// - per-second overtemp check with delay, recovery
module bpm_ctrl #(
   parameter int SEC_CYCLES = bpm_pkg::BPM_SEC_CYCLES,
   parameter int WAKE_HOLD_CYCLES = bpm_pkg::BPM_WAKE_HOLD_CYCLES,
   parameter int DEEP_MEAS_DIV = 4
) (
   input wire logic core_clk,
   input wire logic resetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [15:0] mean_current,
   input wire logic [15:0] temperature,
   input wire logic wake_cmp,
   input wire logic host_activity,
   input wire logic charger_present,
   input wire logic load_present,
   input wire logic lv_charge_allowed,
   input wire logic cell_above_por,
   input wire logic cell_below_uv,
   input wire logic cell_above_uv_release,
   input wire logic cell_below_ov_release,
   input wire logic charger_below_cell,
   input wire logic discharge_overcurrent,
   input wire logic discharge_short_circuit,
   input wire logic charge_overcurrent,
   input wire logic overvoltage_fault,
   output logic charge_switch_on,
   output logic charge_switch_off,
   output logic charge_switch_to_pack,
   output logic discharge_switch_on,
   output logic discharge_switch_off,
   output logic probe_load_en,
   output logic regulator_en,
   output logic hf_osc_en,
   output logic meas_start,
   output logic adc_cal,
   output logic comm_hold_low
);
   initial begin
      if (SEC_CYCLES < 2 || WAKE_HOLD_CYCLES < 1 || DEEP_MEAS_DIV < 2 || DEEP_MEAS_DIV > 256) begin
         $error("bpm_ctrl parameters out of range");
      end
   end
   // synchronisers, stage one is read only by stage two
   localparam int NS = 14;
   logic [NS-1:0] sa_q;
   logic [NS-1:0] sb_q;
   logic [15:0] cur_a_q, cur_b_q, tmp_a_q, tmp_b_q;
   wire logic [NS-1:0] async_in = {wake_cmp, host_activity, charger_present, load_present,
      lv_charge_allowed, cell_above_por, cell_below_uv, cell_above_uv_release,
      cell_below_ov_release, charger_below_cell, discharge_overcurrent,
      discharge_short_circuit, charge_overcurrent, overvoltage_fault};
   // measurement words assumed quasi-static between samples
   always_ff @(posedge core_clk) begin
      sa_q <= async_in;
      sb_q <= sa_q;
      cur_a_q <= mean_current;
      cur_b_q <= cur_a_q;
      tmp_a_q <= temperature;
      tmp_b_q <= tmp_a_q;
   end
   wire logic s_wake = sb_q[13];
   wire logic s_host = sb_q[12];
   wire logic s_chg = sb_q[11];
   wire logic s_load = sb_q[10];
   wire logic s_lva = sb_q[9];
   wire logic s_por = sb_q[8];
   wire logic s_uv = sb_q[7];
   wire logic s_uvrel = sb_q[6];
   wire logic s_ovrel = sb_q[5];
   wire logic s_chgdrop = sb_q[4];
   wire logic s_ocd = sb_q[3];
   wire logic s_scd = sb_q[2];
   // overvoltage wins when both comparators fire
   wire logic s_ov = sb_q[0];
   wire logic s_occ = sb_q[1] & ~sb_q[0];
   // registers
   logic [4:0] ctrl_q;
   logic [1:0] test_q;
   logic [15:0] sleep_cur_q, deep_sleep_wait_time_q, ot_thr_q, ot_dly_q, ot_rec_q, flt_dly_q;
   wire logic acc = psel && penable;
   wire logic wr = acc && pwrite;
   wire logic a_ctrl = paddr == bpm_pkg::BPM_CTRL_OFS;
   wire logic a_scur = paddr == bpm_pkg::BPM_SLEEP_CUR_OFS;
   wire logic a_fsw = paddr == bpm_pkg::BPM_DEEP_SLEEP_WAIT_TIME_OFS;
   wire logic a_otth = paddr == bpm_pkg::BPM_OT_THR_OFS;
   wire logic a_otdl = paddr == bpm_pkg::BPM_OT_DLY_OFS;
   wire logic a_otrc = paddr == bpm_pkg::BPM_OT_REC_OFS;
   wire logic a_fdly = paddr == bpm_pkg::BPM_FLT_DLY_OFS;
   wire logic a_stat = paddr == bpm_pkg::BPM_STATUS_OFS;
   wire logic a_test = paddr == bpm_pkg::BPM_TEST_OFS;
   wire logic a_ok = a_ctrl | a_scur | a_fsw | a_otth | a_otdl | a_otrc | a_fdly | a_stat | a_test;
   bpm_pkg::bpm_pmode_t pm_q, pm_d;
   bpm_pkg::bpm_pstate_t ps_q, ps_d;
   logic deep_flag_q;
   logic ot_active_q;
   wire logic [31:0] status_w = {20'h00000, 1'b0, ot_active_q, deep_flag_q, 3'(pm_q),
      3'(ps_q), 1'b0, 2'(test_q)};
   logic [31:0] rd_w;
   always_comb begin
      if (a_ctrl) rd_w = {27'h0000000, ctrl_q};
      else if (a_scur) rd_w = {16'h0000, sleep_cur_q};
      else if (a_fsw) rd_w = {16'h0000, deep_sleep_wait_time_q};
      else if (a_otth) rd_w = {16'h0000, ot_thr_q};
      else if (a_otdl) rd_w = {16'h0000, ot_dly_q};
      else if (a_otrc) rd_w = {16'h0000, ot_rec_q};
      else if (a_fdly) rd_w = {16'h0000, flt_dly_q};
      else if (a_stat) rd_w = status_w;
      else if (a_test) rd_w = {30'h00000000, test_q};
      else rd_w = 32'h00000000;
   end
   // one wait state in the access phase, pready rises one edge after penable rises
   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h00000000;
      end else begin
         pready <= acc && !pready;
         pslverr <= acc && !pready && !a_ok;
         prdata <= (acc && !pready && !pwrite) ? rd_w : 32'h00000000;
      end
   end
   wire logic wr_go = wr && !pready;
   logic deep_clr;
   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         ctrl_q <= 5'h00;
         test_q <= 2'h0;
         sleep_cur_q <= bpm_pkg::BPM_SLEEP_CUR_RST;
         deep_sleep_wait_time_q <= bpm_pkg::BPM_DEEP_SLEEP_WAIT_TIME_RST;
         ot_thr_q <= bpm_pkg::BPM_OT_THR_RST;
         ot_dly_q <= bpm_pkg::BPM_OT_DLY_RST;
         ot_rec_q <= bpm_pkg::BPM_OT_REC_RST;
         flt_dly_q <= bpm_pkg::BPM_FLT_DLY_RST;
      end else if (wr_go) begin
         if (a_ctrl) ctrl_q <= pwdata[4:0];
         if (a_scur) sleep_cur_q <= pwdata[15:0];
         if (a_fsw) deep_sleep_wait_time_q <= pwdata[15:0];
         if (a_otth) ot_thr_q <= pwdata[15:0];
         if (a_otdl) ot_dly_q <= pwdata[15:0];
         if (a_otrc) ot_rec_q <= pwdata[15:0];
         if (a_fdly) flt_dly_q <= pwdata[15:0];
         if (a_test) test_q <= pwdata[1:0];
      end else if (ps_q == bpm_pkg::BPM_PS_SDWAIT) begin
         ctrl_q[bpm_pkg::BPM_CTRL_SHUTDOWN] <= 1'b0;
      end
   end
   wire logic sd_req = ctrl_q[bpm_pkg::BPM_CTRL_SHUTDOWN];
   // deep sleep request bit: set by command, cleared on wake; set wins
   wire logic deep_set = wr_go && a_ctrl && pwdata[bpm_pkg::BPM_CTRL_DEEP_REQ];
   always_ff @(posedge core_clk) begin
      if (!resetn) deep_flag_q <= 1'b0;
      else if (deep_set) deep_flag_q <= 1'b1;
      else if (deep_clr) deep_flag_q <= 1'b0;
   end
   // one-second tick
   logic [31:0] sec_q;
   wire logic sec_tick = sec_q == 32'(SEC_CYCLES - 1);
   always_ff @(posedge core_clk) begin
      if (!resetn || sec_tick) sec_q <= 32'h00000000;
      else sec_q <= sec_q + 32'h00000001;
   end
   // power mode sequencer
   logic [31:0] pcnt_q;
   logic [15:0] fs_cnt_q;
   wire logic low_cur = cur_b_q < sleep_cur_q;
   wire logic sleep_ok = ctrl_q[bpm_pkg::BPM_CTRL_SLEEP_EN] && low_cur;
   wire logic wake_ev = !low_cur || s_wake;
   wire logic fs_zero = deep_sleep_wait_time_q == 16'h0000;
   wire logic deep_go = (deep_flag_q && fs_zero)
      || (!fs_zero && fs_cnt_q == 16'h0001 && sec_tick);
   always_comb begin
      pm_d = pm_q;
      deep_clr = 1'b0;
      case (pm_q)
         bpm_pkg::BPM_PM_NORMAL: if (sleep_ok) pm_d = bpm_pkg::BPM_PM_CAL;
         bpm_pkg::BPM_PM_CAL: begin
            if (!sleep_ok) pm_d = bpm_pkg::BPM_PM_NORMAL;
            else if (pcnt_q == 32'(bpm_pkg::BPM_CAL_CYCLES - 1)) pm_d = bpm_pkg::BPM_PM_SLEEP;
         end
         bpm_pkg::BPM_PM_SLEEP: begin
            if (wake_ev) pm_d = bpm_pkg::BPM_PM_NORMAL;
            else if (deep_go) pm_d = bpm_pkg::BPM_PM_DEEP;
         end
         bpm_pkg::BPM_PM_DEEP: begin
            if (s_host) pm_d = bpm_pkg::BPM_PM_WAKE;
            else if (wake_ev) pm_d = bpm_pkg::BPM_PM_NORMAL;
            if (s_host || wake_ev) deep_clr = 1'b1;
         end
         bpm_pkg::BPM_PM_WAKE: begin
            if (pcnt_q == 32'(WAKE_HOLD_CYCLES - 1)) pm_d = bpm_pkg::BPM_PM_NORMAL;
         end
         default: pm_d = bpm_pkg::BPM_PM_NORMAL;
      endcase
   end
   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         pm_q <= bpm_pkg::BPM_PM_NORMAL;
         pcnt_q <= 32'h00000000;
      end else begin
         pm_q <= pm_d;
         pcnt_q <= (pm_d != pm_q) ? 32'h00000000 : pcnt_q + 32'h00000001;
      end
   end
   // deep sleep countdown runs only while sleeping
   always_ff @(posedge core_clk) begin
      if (!resetn || pm_q != bpm_pkg::BPM_PM_SLEEP) fs_cnt_q <= deep_sleep_wait_time_q;
      else if (sec_tick && fs_cnt_q != 16'h0000) fs_cnt_q <= fs_cnt_q - 16'h0001;
   end
   // measurement pacing: deep sleep measures every DEEP_MEAS_DIV seconds
   logic [7:0] mdiv_q;
   wire logic deep_meas = mdiv_q == 8'(DEEP_MEAS_DIV - 1);
   always_ff @(posedge core_clk) begin
      if (!resetn || pm_q != bpm_pkg::BPM_PM_DEEP) mdiv_q <= 8'h00;
      else if (sec_tick) mdiv_q <= deep_meas ? 8'h00 : mdiv_q + 8'h01;
   end
   wire logic meas_w = sec_tick && (pm_q != bpm_pkg::BPM_PM_DEEP || deep_meas);
   // fault qualification
   logic ocd_hit, scd_hit, occ_hit, ov_hit, ot_hit;
   bpm_qual #(.W(16)) u_q_ocd (.core_clk(core_clk), .resetn(resetn), .step(1'b1),
      .cond(s_ocd), .limit(flt_dly_q), .hit(ocd_hit));
   bpm_qual #(.W(16)) u_q_scd (.core_clk(core_clk), .resetn(resetn), .step(1'b1),
      .cond(s_scd), .limit(flt_dly_q), .hit(scd_hit));
   bpm_qual #(.W(16)) u_q_occ (.core_clk(core_clk), .resetn(resetn), .step(1'b1),
      .cond(s_occ), .limit(flt_dly_q), .hit(occ_hit));
   bpm_qual #(.W(16)) u_q_ov (.core_clk(core_clk), .resetn(resetn), .step(1'b1),
      .cond(s_ov), .limit(flt_dly_q), .hit(ov_hit));
   // overtemperature, sampled once per second
   logic ot_cond_q;
   always_ff @(posedge core_clk) begin
      if (!resetn) ot_cond_q <= 1'b0;
      else if (sec_tick) ot_cond_q <= tmp_b_q > ot_thr_q;
   end
   bpm_qual #(.W(16)) u_q_ot (.core_clk(core_clk), .resetn(resetn), .step(sec_tick),
      .cond(ot_cond_q), .limit(ot_dly_q), .hit(ot_hit));
   always_ff @(posedge core_clk) begin
      if (!resetn) ot_active_q <= 1'b0;
      else if (ot_hit) ot_active_q <= 1'b1;
      else if (sec_tick && tmp_b_q < ot_rec_q) ot_active_q <= 1'b0;
   end
   wire logic any_fault = ocd_hit | scd_hit | occ_hit | ov_hit | s_uv;
   // protector state machine
   always_comb begin
      ps_d = ps_q;
      case (ps_q)
         bpm_pkg::BPM_PS_ASHUT: if (s_chg && s_lva) ps_d = bpm_pkg::BPM_PS_LVCHG;
         bpm_pkg::BPM_PS_LVCHG: if (s_por) ps_d = bpm_pkg::BPM_PS_UVF;
         bpm_pkg::BPM_PS_UVF: begin
            if (s_uvrel) ps_d = bpm_pkg::BPM_PS_NORMAL;
            else if (!s_chg) ps_d = bpm_pkg::BPM_PS_ASHUT;
         end
         bpm_pkg::BPM_PS_NORMAL: begin
            if (ocd_hit || scd_hit) ps_d = bpm_pkg::BPM_PS_DSGF;
            else if (ov_hit) ps_d = bpm_pkg::BPM_PS_OVF;
            else if (occ_hit) ps_d = bpm_pkg::BPM_PS_OCCF;
            else if (s_uv) ps_d = bpm_pkg::BPM_PS_UVF;
            else if (sd_req) ps_d = bpm_pkg::BPM_PS_SDWAIT;
         end
         bpm_pkg::BPM_PS_SDWAIT: begin
            if (any_fault) ps_d = bpm_pkg::BPM_PS_NORMAL;
            else if (!s_chg) ps_d = bpm_pkg::BPM_PS_ASHUT;
         end
         bpm_pkg::BPM_PS_DSGF: if (!s_load) ps_d = bpm_pkg::BPM_PS_NORMAL;
         bpm_pkg::BPM_PS_OCCF: if (s_chgdrop) ps_d = bpm_pkg::BPM_PS_NORMAL;
         bpm_pkg::BPM_PS_OVF: if (s_chgdrop && s_ovrel) ps_d = bpm_pkg::BPM_PS_NORMAL;
         default: ps_d = bpm_pkg::BPM_PS_ASHUT;
      endcase
   end
   always_ff @(posedge core_clk) begin
      if (!resetn) ps_q <= bpm_pkg::BPM_PS_UVF;
      else ps_q <= ps_d;
   end
   // switch drive: hardware closes, firmware and test may only open
   wire logic hw_chg = ps_q == bpm_pkg::BPM_PS_NORMAL;
   wire logic hw_dsg = ps_q == bpm_pkg::BPM_PS_NORMAL || ps_q == bpm_pkg::BPM_PS_OCCF
      || ps_q == bpm_pkg::BPM_PS_OVF;
   wire logic chg_ok = hw_chg && !ctrl_q[bpm_pkg::BPM_CTRL_OVR_CHG]
      && !test_q[bpm_pkg::BPM_TEST_CHG_OFF] && !ot_active_q;
   wire logic dsg_ok = hw_dsg && !ctrl_q[bpm_pkg::BPM_CTRL_OVR_DSG]
      && !test_q[bpm_pkg::BPM_TEST_DSG_OFF] && !ot_active_q;
   wire logic lv_path = ps_q == bpm_pkg::BPM_PS_LVCHG;
   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         charge_switch_on <= 1'b0;
         charge_switch_off <= 1'b1;
         charge_switch_to_pack <= 1'b0;
         discharge_switch_on <= 1'b0;
         discharge_switch_off <= 1'b1;
         probe_load_en <= 1'b0;
         regulator_en <= 1'b1;
         hf_osc_en <= 1'b1;
         meas_start <= 1'b0;
         adc_cal <= 1'b0;
         comm_hold_low <= 1'b0;
      end else begin
         charge_switch_on <= chg_ok;
         charge_switch_off <= !chg_ok && !lv_path;
         charge_switch_to_pack <= lv_path;
         discharge_switch_on <= dsg_ok;
         discharge_switch_off <= !dsg_ok;
         probe_load_en <= ps_q == bpm_pkg::BPM_PS_DSGF;
         regulator_en <= ps_q != bpm_pkg::BPM_PS_ASHUT && ps_q != bpm_pkg::BPM_PS_LVCHG;
         hf_osc_en <= pm_q != bpm_pkg::BPM_PM_DEEP;
         meas_start <= meas_w;
         adc_cal <= pm_q == bpm_pkg::BPM_PM_CAL;
         comm_hold_low <= pm_q == bpm_pkg::BPM_PM_WAKE;
      end
   end
endmodule : bpm_ctrl
`default_nettype wire

// [hdl/bpm_pkg.sv]
// bpm_pkg: register map, reset values and timing
// assumes a 100 MHz core clock and a 32-bit apb slave port
package bpm_pkg;
   // register byte offsets
   localparam logic [7:0] BPM_CTRL_OFS = 8'h00;
   localparam logic [7:0] BPM_SLEEP_CUR_OFS = 8'h04;
   localparam logic [7:0] BPM_DEEP_SLEEP_WAIT_TIME_OFS = 8'h08;
   localparam logic [7:0] BPM_OT_THR_OFS = 8'h0c;
   localparam logic [7:0] BPM_OT_DLY_OFS = 8'h10;
   localparam logic [7:0] BPM_OT_REC_OFS = 8'h14;
   localparam logic [7:0] BPM_FLT_DLY_OFS = 8'h18;
   localparam logic [7:0] BPM_STATUS_OFS = 8'h1c;
   localparam logic [7:0] BPM_TEST_OFS = 8'h20;
   // control register fields
   localparam int BPM_CTRL_SLEEP_EN = 0;
   localparam int BPM_CTRL_DEEP_REQ = 1;
   localparam int BPM_CTRL_SHUTDOWN = 2;
   localparam int BPM_CTRL_OVR_CHG = 3;
   localparam int BPM_CTRL_OVR_DSG = 4;
   // switch test fields
   localparam int BPM_TEST_CHG_OFF = 0;
   localparam int BPM_TEST_DSG_OFF = 1;
   // reset values
   localparam logic [15:0] BPM_SLEEP_CUR_RST = 16'h000a;
   localparam logic [15:0] BPM_DEEP_SLEEP_WAIT_TIME_RST = 16'h0000;
   localparam logic [15:0] BPM_OT_THR_RST = 16'h0226;
   localparam logic [15:0] BPM_OT_DLY_RST = 16'h0002;
   localparam logic [15:0] BPM_OT_REC_RST = 16'h01f4;
   localparam logic [15:0] BPM_FLT_DLY_RST = 16'h0010;
   // timing
   localparam int BPM_CLK_HZ = 100000000;
   localparam int BPM_TICK_MS = 1000;
   localparam int BPM_SEC_CYCLES = BPM_CLK_HZ / 1000 * BPM_TICK_MS;
   localparam int BPM_WAKE_HOLD_MS = 4;
   localparam int BPM_WAKE_HOLD_CYCLES = BPM_CLK_HZ / 1000 * BPM_WAKE_HOLD_MS;
   localparam int BPM_CAL_CYCLES = 64;
   // power modes
   typedef enum logic [2:0] {
      BPM_PM_NORMAL = 3'b000,
      BPM_PM_CAL = 3'b001,
      BPM_PM_SLEEP = 3'b010,
      BPM_PM_DEEP = 3'b011,
      BPM_PM_WAKE = 3'b100
   } bpm_pmode_t;
   // protector states
   typedef enum logic [2:0] {
      BPM_PS_ASHUT = 3'b000,
      BPM_PS_LVCHG = 3'b001,
      BPM_PS_UVF = 3'b010,
      BPM_PS_NORMAL = 3'b011,
      BPM_PS_SDWAIT = 3'b100,
      BPM_PS_DSGF = 3'b101,
      BPM_PS_OCCF = 3'b110,
      BPM_PS_OVF = 3'b111
   } bpm_pstate_t;
endpackage : bpm_pkg

// [hdl/bpm_qual.sv]
// bpm_qual: fault qualification counter
// assumes cond is synchronous to core_clk
`timescale 1ns/100ps
`default_nettype none
module bpm_qual #(
   parameter int W = 16
) (
   input wire logic core_clk,
   input wire logic resetn,
   input wire logic step,
   input wire logic cond,
   input wire logic [W-1:0] limit,
   output logic hit
);
   logic [W-1:0] cnt_q;
   initial begin
      if (W < 2) $error("bpm_qual width too small");
   end
   // any dropout restarts the count, only unbroken violations qualify
   always_ff @(posedge core_clk) begin
      if (!resetn || !cond) begin
         cnt_q <= '0;
      end else if (step && cnt_q != limit) begin
         cnt_q <= cnt_q + 1'b1;
      end
   end
   assign hit = cond && (cnt_q == limit);
endmodule : bpm_qual
`default_nettype wire
